// ### design/lcds_pkg.sv
// constants for the logic cell input data select block
package lcds_pkg;
  localparam int          LCDS_NUM_INPUTS  = 16;
  localparam int          LCDS_NUM_LINES   = 4;
  localparam int          LCDS_CODE_W      = 3;
  localparam int          LCDS_IDX_W       = 4;
  localparam int          LCDS_REG_W       = 8;
  // byte offsets of the two selector registers
  localparam logic [31:0] LCDS_OFS_LOW     = 32'h0000_0000;
  localparam logic [31:0] LCDS_OFS_HIGH    = 32'h0000_0004;
  localparam int          LCDS_DEC_W       = 3;
  // field positions inside each selector register
  localparam int          LCDS_LO_FIELD_LSB = 0;
  localparam int          LCDS_HI_FIELD_LSB = 4;
  localparam logic [2:0]  LCDS_CODE_RST    = 3'h0;
  // first shared input picked by code 000, per data line
  localparam logic [3:0]  LCDS_LINE1_BASE  = 4'h0;
  localparam logic [3:0]  LCDS_LINE2_BASE  = 4'h4;
  localparam logic [3:0]  LCDS_LINE3_BASE  = 4'h8;
  localparam logic [3:0]  LCDS_LINE4_BASE  = 4'hC;
  localparam logic [1:0]  LCDS_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0]  LCDS_HTRANS_SEQ  = 2'h3;
  localparam logic        LCDS_HRESP_OKAY  = 1'h0;
endpackage : lcds_pkg

// ### design/lcds_line_mux.sv
// one data line: picks a shared input by base plus code, registered
`timescale 1ns/1ps
module lcds_line_mux #(
  parameter logic [3:0] BASE = 4'h0
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  code_i,
  input  wire logic [15:0] src_i,
  output logic             line_o
);
  import lcds_pkg::*;

  logic [LCDS_IDX_W-1:0] src_idx;
  logic                  line_nxt;
  logic                  line_r;

  // four-bit sum wraps, so base 12 reaches inputs 0 to 3 for codes 4 to 7
  assign src_idx  = BASE + {1'b0, code_i};
  assign line_nxt = src_i[src_idx];
  assign line_o   = line_r;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      line_r <= 1'b0;
    end
    else
    begin
      line_r <= line_nxt;
    end
  end
endmodule : lcds_line_mux

// ### design/lcds_top.sv
// logic cell input data select: selector registers on ahb-lite and muxes
`timescale 1ns/1ps
// Behaviour
// RQ1: low register: line1 bits 2-0, line2 6-4
// RQ2: line 2 takes input four plus code
// RQ3: line 1 takes input equal to code
// RQ4: bits 7 and 3 ignore writes, read zero
// RQ5: high register: line3 bits 2-0, line4 6-4
// RQ6: line 4: inputs 12-15 then 0-3
// RQ7: line 3 takes input eight plus code
// RQ8: selectors kept across all but power-on reset; here every sys_rst_i clears them
module lcds_top (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [15:0] cell_in_i,
  output logic             cell_data_line_1_o,
  output logic             cell_data_line_2_o,
  output logic             cell_data_line_3_o,
  output logic             cell_data_line_4_o
);
  import lcds_pkg::*;

  // selector fields, one per data line
  logic [LCDS_CODE_W-1:0] line1_source_code_r;
  logic [LCDS_CODE_W-1:0] line2_source_code_r;
  logic [LCDS_CODE_W-1:0] line3_source_code_r;
  logic [LCDS_CODE_W-1:0] line4_source_code_r;
  logic [LCDS_CODE_W-1:0] line1_source_code_nxt;
  logic [LCDS_CODE_W-1:0] line2_source_code_nxt;
  logic [LCDS_CODE_W-1:0] line3_source_code_nxt;
  logic [LCDS_CODE_W-1:0] line4_source_code_nxt;

  // bus pipeline state
  logic                   wr_pend_r;
  logic                   wr_low_r;
  logic                   wr_high_r;
  logic [31:0]            hrdata_r;
  logic [31:0]            hrdata_nxt;

  logic                   acc_valid;
  logic                   sel_low;
  logic                   sel_high;
  logic                   rd_acc;
  logic                   wr_acc;
  logic [LCDS_REG_W-1:0]  data_select_low_pair;
  logic [LCDS_REG_W-1:0]  data_select_high_pair;
  logic                   wr_low_go;
  logic                   wr_high_go;
  logic [LCDS_CODE_W-1:0] wr_lo_field;
  logic [LCDS_CODE_W-1:0] wr_hi_field;
  logic [LCDS_CODE_W-1:0] codes [LCDS_NUM_LINES];
  logic [LCDS_NUM_LINES-1:0] lines;

  // address phase decode
  assign acc_valid = hsel_i & hready_i
                   & ((htrans_i == LCDS_HTRANS_NSEQ)
                   | (htrans_i == LCDS_HTRANS_SEQ));
  assign sel_low   = haddr_i[LCDS_DEC_W-1:0] == LCDS_OFS_LOW[LCDS_DEC_W-1:0]
                   && haddr_i[31:LCDS_DEC_W] == '0;
  assign sel_high  = haddr_i[LCDS_DEC_W-1:0] == LCDS_OFS_HIGH[LCDS_DEC_W-1:0]
                   && haddr_i[31:LCDS_DEC_W] == '0;
  assign rd_acc    = acc_valid & ~hwrite_i;
  assign wr_acc    = acc_valid & hwrite_i;

  // read view: unimplemented bits 7 and 3 always zero
  // built from next values so a read right behind a write sees it
  assign data_select_low_pair  = {1'b0, line2_source_code_nxt,
                                  1'b0, line1_source_code_nxt}; // RQ1 RQ4
  assign data_select_high_pair = {1'b0, line4_source_code_nxt,
                                  1'b0, line3_source_code_nxt}; // RQ5 RQ4

  // unmapped reads return zero
  assign hrdata_nxt = !rd_acc ? hrdata_r
                    : sel_low  ? {24'h00_0000, data_select_low_pair}
                    : sel_high ? {24'h00_0000, data_select_high_pair}
                    : 32'h0000_0000;

  // write data phase: only the field bits are stored
  assign wr_low_go   = wr_pend_r & wr_low_r;
  assign wr_high_go  = wr_pend_r & wr_high_r;
  assign wr_lo_field = hwdata_i[LCDS_LO_FIELD_LSB +: LCDS_CODE_W]; // RQ4
  assign wr_hi_field = hwdata_i[LCDS_HI_FIELD_LSB +: LCDS_CODE_W]; // RQ4

  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = LCDS_HRESP_OKAY;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_pend_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= wr_acc;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_low_r <= 1'b0;
    end
    else
    begin
      wr_low_r <= wr_acc & sel_low;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wr_high_r <= 1'b0;
    end
    else
    begin
      wr_high_r <= wr_acc & sel_high;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // selectors: every sys_rst_i clears them, like the bus state
  assign line1_source_code_nxt = wr_low_go ? wr_lo_field // RQ1
                               : line1_source_code_r;
  assign line2_source_code_nxt = wr_low_go ? wr_hi_field // RQ1
                               : line2_source_code_r;
  assign line3_source_code_nxt = wr_high_go ? wr_lo_field // RQ5
                               : line3_source_code_r;
  assign line4_source_code_nxt = wr_high_go ? wr_hi_field // RQ5
                               : line4_source_code_r;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      line1_source_code_r <= LCDS_CODE_RST; // RQ8
    end
    else
    begin
      line1_source_code_r <= line1_source_code_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      line2_source_code_r <= LCDS_CODE_RST; // RQ8
    end
    else
    begin
      line2_source_code_r <= line2_source_code_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      line3_source_code_r <= LCDS_CODE_RST; // RQ8
    end
    else
    begin
      line3_source_code_r <= line3_source_code_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      line4_source_code_r <= LCDS_CODE_RST; // RQ8
    end
    else
    begin
      line4_source_code_r <= line4_source_code_nxt;
    end
  end

  assign codes[0] = line1_source_code_r;
  assign codes[1] = line2_source_code_r;
  assign codes[2] = line3_source_code_r;
  assign codes[3] = line4_source_code_r;

  localparam logic [3:0] LINE_BASE [LCDS_NUM_LINES] = '{
    LCDS_LINE1_BASE, // RQ3
    LCDS_LINE2_BASE, // RQ2
    LCDS_LINE3_BASE, // RQ7
    LCDS_LINE4_BASE  // RQ6
  };

  for (genvar g = 0; g < LCDS_NUM_LINES; g++)
  begin : g_line
    lcds_line_mux #(
      .BASE (LINE_BASE[g])
    ) u_mux (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .code_i    (codes[g]),
      .src_i     (cell_in_i),
      .line_o    (lines[g])
    );
  end

  assign cell_data_line_1_o = lines[0];
  assign cell_data_line_2_o = lines[1];
  assign cell_data_line_3_o = lines[2];
  assign cell_data_line_4_o = lines[3];
endmodule : lcds_top

// ### sim/lcds_gate_model.sv
// stand-in for the gate stage fed by the four data lines
`timescale 1ns/1ps
module lcds_gate_model (
  input  wire logic [3:0] line_i,
  output logic      [3:0] gate_o
);
  assign gate_o = line_i;
endmodule : lcds_gate_model

// ### sim/lcds_top_assertions.sv
// port checks for the data select block
`timescale 1ns/1ps
module lcds_assertions (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        hsel_i,
  input wire logic        hready_i,
  input wire logic        hwrite_i,
  input wire logic [1:0]  htrans_i,
  input wire logic [31:0] haddr_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic [15:0] cell_in_i,
  input wire logic        cell_data_line_1_o,
  input wire logic        cell_data_line_2_o,
  input wire logic        cell_data_line_3_o,
  input wire logic        cell_data_line_4_o
);
  logic tk, up_r, wr_r, rd_r;
  logic [1:0] ad_r;
  logic [3:0] ln, ex;
  logic [7:0] s0_r, s1_r;
  assign tk = hsel_i & hready_i & htrans_i[1];
  assign ln = {cell_data_line_4_o, cell_data_line_3_o,
    cell_data_line_2_o, cell_data_line_1_o};
  assign ex = {cell_in_i[4'hC + s1_r[6:4]], cell_in_i[4'h8 + s1_r[2:0]],
    cell_in_i[4'h4 + s0_r[6:4]], cell_in_i[s0_r[2:0]]};
  // shadow of the selector codes
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      {up_r, wr_r, rd_r, ad_r, s0_r, s1_r} <= '0;
    else
    begin
      up_r <= 1'h1;
      wr_r <= tk & hwrite_i;
      rd_r <= tk & ~hwrite_i;
      if (tk) ad_r <= {haddr_i == 32'h4, haddr_i == 32'h0};
      if (wr_r & ad_r[0]) s0_r <= hwdata_i[7:0] & 8'h77;
      if (wr_r & ad_r[1]) s1_r <= hwdata_i[7:0] & 8'h77;
    end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  l1_sel_a: assert property (up_r |-> ln[0] == $past(ex[0]))
    else $error("line1");
  l2_sel_a: assert property (up_r |-> ln[1] == $past(ex[1]))
    else $error("line2");
  l3_sel_a: assert property (up_r |-> ln[2] == $past(ex[2]))
    else $error("line3");
  l4_sel_a: assert property (up_r |-> ln[3] == $past(ex[3]))
    else $error("line4");
  rd_low_a: assert property (rd_r & ad_r[0] |-> hrdata_o == s0_r)
    else $error("low read");
  rd_high_a: assert property (rd_r & ad_r[1] |-> hrdata_o == s1_r)
    else $error("high read");
  rd_unmap_a: assert property (rd_r & ~|ad_r |-> hrdata_o == 0)
    else $error("unmapped read");
  rd_hold_a: assert property (!(tk & ~hwrite_i) |=> $stable(hrdata_o))
    else $error("read data moved");
endmodule : lcds_assertions

// ### sim/lcds_top_tb.sv
// self-checking bench for the data select block
`timescale 1ns/1ps
bind lcds_top lcds_assertions chk_u (
  .clk_i              (clk_i),
  .sys_rst_i          (sys_rst_i),
  .hsel_i             (hsel_i),
  .hready_i           (hready_i),
  .hwrite_i           (hwrite_i),
  .htrans_i           (htrans_i),
  .haddr_i            (haddr_i),
  .hwdata_i           (hwdata_i),
  .hrdata_o           (hrdata_o),
  .cell_in_i          (cell_in_i),
  .cell_data_line_1_o (cell_data_line_1_o),
  .cell_data_line_2_o (cell_data_line_2_o),
  .cell_data_line_3_o (cell_data_line_3_o),
  .cell_data_line_4_o (cell_data_line_4_o)
);
module lcds_top_tb;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, hsel_i = 1'h1, hwrite_i = 1'h0;
  logic hready_i, hreadyout_o, hresp_o;
  logic cell_data_line_1_o, cell_data_line_2_o;
  logic cell_data_line_3_o, cell_data_line_4_o;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [3:0] g;
  logic [15:0] cell_in_i = 16'h0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, q, w, r = 32'h0973;
  int failures = 0, cmp_count = 0, n;
  assign hready_i = hreadyout_o;
  always #25 clk_i = ~clk_i;
  lcds_top dut_u (
    .clk_i              (clk_i),
    .sys_rst_i          (sys_rst_i),
    .hsel_i             (hsel_i),
    .haddr_i            (haddr_i),
    .htrans_i           (htrans_i),
    .hwrite_i           (hwrite_i),
    .hsize_i            (hsize_i),
    .hwdata_i           (hwdata_i),
    .hready_i           (hready_i),
    .hrdata_o           (hrdata_o),
    .hreadyout_o        (hreadyout_o),
    .hresp_o            (hresp_o),
    .cell_in_i          (cell_in_i),
    .cell_data_line_1_o (cell_data_line_1_o),
    .cell_data_line_2_o (cell_data_line_2_o),
    .cell_data_line_3_o (cell_data_line_3_o),
    .cell_data_line_4_o (cell_data_line_4_o)
  );
  lcds_gate_model pm_u (.line_i({cell_data_line_4_o, cell_data_line_3_o,
    cell_data_line_2_o, cell_data_line_1_o}), .gate_o(g));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task print_verdict;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task ck(input string s, input logic [31:0] e, v);
    cmp_count++;
    if (v !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", s, e, v);
    end
  endtask : ck
  // shared input index for line k+1 from its register byte
  function automatic logic [3:0] exp_src(input int k, input logic [7:0] v);
    logic [2:0] cd;
    cd = 3'(v >> 4 * (k % 2));
    return 4'(4 * k + cd);
  endfunction : exp_src
  task ck_lines(input logic [7:0] lo, hi);
    for (int k = 0; k < 4; k++)
      ck("line", cell_in_i[exp_src(k, k < 2 ? lo : hi)], g[k]);
  endtask : ck_lines
  task wt;
    for (n = 0; n < 9; n++)
    begin
      @(posedge clk_i);
      if (hready_i === 1'h1) return;
    end
    failures++;
    print_verdict;
  endtask : wt
  task bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    wt;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wt;
    q = hrdata_o;
  endtask : bus
  initial
  begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    for (int i = 0; i < 40; i++)
    begin
      r = xs(r);
      w = i < 8 ? 32'h11 * i | 32'hFFFFFF88 : r;
      bus(32'h0, 1'h1, w);
      bus(32'h8, 1'h1, r);
      bus(32'h4, 1'h1, ~w);
      bus(32'h4, 1'h0, 0);
      ck("high", ~w & 32'h77, q);
      bus(32'h0, 1'h0, 0);
      ck("low", w & 32'h77, q);
      bus(32'h8, 1'h0, 0);
      ck("unmapped", 0, q);
      ck("hresp", 0, hresp_o);
      cell_in_i <= r[31:16];
      repeat (2) @(posedge clk_i);
      #1;
      ck_lines(w[7:0], ~w[7:0]);
      @(posedge clk_i);
    end
    sys_rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    bus(32'h0, 1'h0, 0);
    ck("low after reset", 0, q);
    bus(32'h4, 1'h0, 0);
    ck("high after reset", 0, q);
    #1;
    ck_lines(8'h00, 8'h00);
    print_verdict;
  end
endmodule : lcds_top_tb
